//--- swb_pkg.sv
package swb_pkg;

  // ==========================================================
  // memory-mapped locations
  localparam logic [11:0] ADDR_SP     = 12'hF80;
  localparam logic [11:0] ADDR_SBS    = 12'hF84;
  localparam logic [11:0] ADDR_PSW_LO = 12'hFB0;
  localparam logic [11:0] ADDR_PSW_HI = 12'hFB1;

  // ==========================================================
  // reset values and fixed register bank
  localparam logic [7:0] SP_RESET  = 8'h00;
  localparam logic [3:0] SBS_RESET = 4'h8;
  localparam logic [3:0] MB_RESET  = 4'h0;
  localparam logic [1:0] RB_RESET  = 2'h0;
  localparam logic [1:0] RB_FIXED  = 2'h0;

  // ==========================================================
  // legal data memory banks
  localparam logic [3:0] MB_BANK0  = 4'h0;
  localparam logic [3:0] MB_BANK1  = 4'h1;
  localparam logic [3:0] MB_BANK15 = 4'hF;

  // ==========================================================
  // field positions
  localparam int BOOT_MBE_BIT = 7;
  localparam int BOOT_RBE_BIT = 6;
  localparam int VEC_MBE_BIT  = 7;
  localparam int VEC_RBE_BIT  = 6;
  localparam int SBS_MODE_BIT = 3;

  // ==========================================================
  // interrupt status codes
  localparam logic [1:0] IST_S0 = 2'h0;
  localparam logic [1:0] IST_S1 = 2'h1;
  localparam logic [1:0] IST_S2 = 2'h2;

  // ==========================================================
  // frame lengths in nibbles
  localparam logic [2:0] NIB_CALL = 3'h4;
  localparam logic [2:0] NIB_INT  = 3'h6;
  localparam logic [2:0] NIB_PAIR = 3'h2;

  // ==========================================================
  // commands from the sequencer
  typedef enum logic [3:0] {
    CMD_NONE,
    CMD_CALL,
    CMD_INT,
    CMD_RET,
    CMD_INTERRUPT_EXIT_OP,
    CMD_PUSH_PAIR,
    CMD_POP_PAIR,
    CMD_PUSH_BS,
    CMD_POP_BS
  } swb_cmd_type;

  typedef enum logic [3:0] {
    CY_NONE,
    CY_SET,
    CY_CLR,
    CY_NOT,
    CY_SKT,
    CY_ARITH,
    CY_MOVE_IN,
    CY_AND,
    CY_OR,
    CY_XOR
  } swb_cy_op_type;

endpackage : swb_pkg

//--- swb_stk_if.sv
interface swb_stk_if;
  logic        push;
  logic        pop;
  logic        sp_we;
  logic        sbs_we;
  logic [7:0]  sp_wdata;
  logic [3:0]  sbs_wdata;
  logic [7:0]  sp;
  logic [3:0]  stack_bank_selector;
  logic [11:0] addr;

  modport ctl  (output push, pop, sp_we, sbs_we, sp_wdata, sbs_wdata, input  sp, stack_bank_selector, addr);
  modport unit (input  push, pop, sp_we, sbs_we, sp_wdata, sbs_wdata, output sp, stack_bank_selector, addr);
endinterface : swb_stk_if

//--- swb_stack_unit.sv
module swb_stack_unit (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // stack control
  swb_stk_if.unit  stk
);
  import swb_pkg::*;

  logic [7:0] sp_q;
  logic [3:0] sbs_q;
  wire  [7:0] sp_dec = sp_q - 8'h01;
  wire  [7:0] sp_inc = sp_q + 8'h01;

  assign stk.sp   = sp_q;
  assign stk.stack_bank_selector  = sbs_q;
  // bank from the selector, offset wraps inside the bank
  assign stk.addr = {2'h0, sbs_q[1:0], stk.push ? sp_dec : sp_q};

  // ==========================================================
  // pointer and bank selector
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sp_q  <= SP_RESET;
      sbs_q <= SBS_RESET;
    end else begin
      if (stk.push) begin
        sp_q <= sp_dec;
      end else if (stk.pop) begin
        sp_q <= sp_inc;
      end else if (stk.sp_we) begin
        sp_q <= stk.sp_wdata;
      end
      if (stk.sbs_we) begin
        sbs_q <= stk.sbs_wdata;
      end
    end
  end

  // ==========================================================
  // checks
  push_wrap_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (stk.push && sp_q == 8'h00) |-> stk.addr[7:0] == 8'hFF && stk.addr[9:8] == sbs_q[1:0])
    else $error("push from zero pointer missed bank top");
  sp_dec_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    stk.push |=> sp_q == $past(sp_dec))
    else $error("pointer did not step down on push");
  sp_inc_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (stk.pop && !stk.push) |=> sp_q == $past(sp_inc))
    else $error("pointer did not step up on pop");

endmodule : swb_stack_unit

//--- swb_carry_unit.sv
module swb_carry_unit (
  // clock and reset
  input wire logic                   i_clk,
  input wire logic                   i_rst_n,
  // operation
  input wire swb_pkg::swb_cy_op_type i_op,
  input wire logic                   i_alu_carry,
  input wire logic                   i_mem_bit,
  input wire logic                   i_load,
  input wire logic                   i_load_val,
  // state
  output logic                       o_carry,
  output logic                       o_skip
);
  import swb_pkg::*;

  logic carry_q;
  logic carry_d;

  always_comb begin
    carry_d = carry_q;
    if (i_load) begin
      carry_d = i_load_val;
    end else begin
      case (i_op)
        CY_SET:     carry_d = 1'b1;
        CY_CLR:     carry_d = 1'b0;
        CY_NOT:     carry_d = ~carry_q;
        CY_ARITH:   carry_d = i_alu_carry;
        CY_MOVE_IN: carry_d = i_mem_bit;
        CY_AND:     carry_d = carry_q & i_mem_bit;
        CY_OR:      carry_d = carry_q | i_mem_bit;
        CY_XOR:     carry_d = carry_q ^ i_mem_bit;
        default:    carry_d = carry_q;
      endcase
    end
  end

  // reset value is only for a clean start; software must not rely on it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      carry_q <= 1'b0;
    end else begin
      carry_q <= carry_d;
    end
  end

  assign o_carry = carry_q;
  assign o_skip  = (i_op == CY_SKT) && carry_q;

  // ==========================================================
  // checks
  cy_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_op == CY_SET && !i_load) |=> carry_q)
    else $error("carry not set");
  cy_not_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_op == CY_NOT && !i_load) |=> carry_q != $past(carry_q))
    else $error("carry not inverted");
  cy_and_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_op == CY_AND && !i_load) |=> carry_q == ($past(carry_q) & $past(i_mem_bit)))
    else $error("carry and result wrong");

endmodule : swb_carry_unit

//--- swb_ctx.sv
// Notes on behaviour
// - zero pointer pushes first to bank top
// - call pushes only the two bank enables
// - interrupt pushes every status bit
// - return restores enables, interrupt return everything
// - extended mode frames keep only bank enables; frames here do not depend on the mode
// - status word at two addresses, low writable
// - carry catches add and subtract carry
// - carry undefined after reset
// - set, clear, invert, skip-if-set carry
// - bit and/or/xor into carry, moves
// - skip bits hardware-only, not an operand
// - interrupt status gates which levels allowed
// - acknowledge pushes status, then steps up
// - data bank from selector only when enabled
// - reset loads enables from program word zero
// - vector bit 7 loads data bank enable
// - vector bit 6 loads register bank enable
// - register bank zero unless enabled
// - bank selection pushed and popped whole
// - data bank selector 0,1,15, reset zero
// - register bank selector 0-3, reset zero
// - pointer pre-decrements push, post-increments pop
// - stack wraps inside selected bank
// - pointer undefined, stack bank 1000b at reset
module swb_ctx (
  // clock and reset
  input  wire  logic                 i_clk,
  input  wire  logic                 i_rst_n,
  // frame requests from the sequencer
  input  wire  swb_pkg::swb_cmd_type i_cmd,
  input  wire  logic [12:0]          i_ret_pc,
  input  wire  logic [7:0]           i_push_data,
  input  wire  logic [7:0]           i_vec_word,
  input  wire  logic [7:0]           i_boot_word,
  output logic                       o_busy,
  output logic                       o_done,
  output logic [12:0]                o_pop_pc,
  output logic [7:0]                 o_pop_data,
  // stack memory port
  output logic [11:0]                o_stk_addr,
  output logic                       o_stk_we,
  output logic                       o_stk_re,
  output logic [3:0]                 o_stk_wdata,
  input  wire  logic [3:0]           i_stk_rdata,
  // carry operations
  input  wire  swb_pkg::swb_cy_op_type i_cy_op,
  input  wire  logic                 i_alu_carry,
  input  wire  logic                 i_mem_bit,
  output logic                       o_carry,
  output logic                       o_skip_carry,
  // skip state from execution
  input  wire  logic                 i_skip_we,
  input  wire  logic [2:0]           i_skip_state,
  // bank selection
  input  wire  logic                 i_sel_mb_we,
  input  wire  logic [3:0]           i_sel_mb,
  input  wire  logic                 i_sel_rb_we,
  input  wire  logic [1:0]           i_sel_rb,
  input  wire  logic [3:0]           i_fixed_bank,
  output logic [3:0]                 o_data_bank_hi,
  output logic [1:0]                 o_reg_bank,
  // memory-mapped access
  input  wire  logic                 i_mem_we,
  input  wire  logic                 i_mem_re,
  input  wire  logic [11:0]          i_mem_addr,
  input  wire  logic [7:0]           i_mem_wdata,
  output logic [7:0]                 o_mem_rdata,
  // interrupt gating and mode
  output logic                       o_irq_allow_all,
  output logic                       o_irq_allow_high,
  output logic                       o_extended_mode
);
  import swb_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_PUSH, ST_POP, ST_FINISH} swb_state_type;

  // ==========================================================
  // state
  swb_state_type state_q;
  swb_state_type state_d;
  swb_cmd_type   cmd_q;
  logic [2:0]    cnt_q;
  logic [2:0]    len_q;
  logic [12:0]   pc_q;
  logic [7:0]    data_q;
  logic [7:0]    vec_q;
  logic [1:0]    ist_q;
  logic          mbe_q;
  logic          rbe_q;
  logic [2:0]    skip_q;
  logic [3:0]    mbs_q;
  logic [1:0]    rbs_q;
  logic          boot_q;
  logic          rd_valid_q;
  logic [2:0]    rd_idx_q;
  logic          done_q;
  logic [7:0]    mem_rdata_q;
  logic [3:0]    push_nib;
  logic          carry;

  swb_stk_if stk ();

  // ==========================================================
  // decode
  wire       idle      = (state_q == ST_IDLE);
  wire       start     = idle && (i_cmd != CMD_NONE);
  wire       push_cmd  = (i_cmd == CMD_CALL) || (i_cmd == CMD_INT) ||
                         (i_cmd == CMD_PUSH_PAIR) || (i_cmd == CMD_PUSH_BS);
  wire       long_cmd  = (i_cmd == CMD_INT) || (i_cmd == CMD_INTERRUPT_EXIT_OP);
  wire       call_cmd  = (i_cmd == CMD_CALL) || (i_cmd == CMD_RET);
  wire [2:0] start_len = long_cmd ? NIB_INT : (call_cmd ? NIB_CALL : NIB_PAIR);
  wire       last      = (cnt_q == len_q - 3'h1);
  wire       extended  = stk.stack_bank_selector[SBS_MODE_BIT];
  wire       wr_psw_lo = i_mem_we && (i_mem_addr == ADDR_PSW_LO);
  wire       wr_sp     = i_mem_we && (i_mem_addr == ADDR_SP);
  wire       wr_sbs    = i_mem_we && (i_mem_addr == ADDR_SBS);
  wire       cap_ret   = rd_valid_q && ((cmd_q == CMD_RET) || (cmd_q == CMD_INTERRUPT_EXIT_OP));
  wire       cap_interrupt_exit_op  = rd_valid_q && (cmd_q == CMD_INTERRUPT_EXIT_OP);
  wire       cap_data  = rd_valid_q && ((cmd_q == CMD_POP_PAIR) || (cmd_q == CMD_POP_BS));
  wire       cap_bs    = rd_valid_q && (cmd_q == CMD_POP_BS);
  wire       pair_push = (cmd_q == CMD_PUSH_PAIR) || (cmd_q == CMD_PUSH_BS);
  wire [2:0] call_idx  = (cmd_q == CMD_INT) ? cnt_q - 3'h2 : cnt_q;
  wire [1:0] ist_next  = (ist_q == IST_S0) ? IST_S1 : IST_S2;
  wire       mb_legal  = (i_sel_mb == MB_BANK0) || (i_sel_mb == MB_BANK1) || (i_sel_mb == MB_BANK15);
  wire       int_done  = (state_q == ST_FINISH) && (cmd_q == CMD_INT);
  wire       ret_bank  = cap_ret && (cmd_q == CMD_RET) && (rd_idx_q == 3'h1);
  wire       interrupt_exit_op_psw  = cap_interrupt_exit_op && (rd_idx_q == 3'h4);
  wire       interrupt_exit_op_cy   = cap_interrupt_exit_op && (rd_idx_q == 3'h5);
  wire [7:0] bs_word   = {mbs_q, 2'h0, rbs_q};
  wire [7:0] rd_mux    = (i_mem_addr == ADDR_PSW_LO) ? {4'h0, ist_q, mbe_q, rbe_q} :
                         (i_mem_addr == ADDR_PSW_HI) ? {4'h0, carry, skip_q} :
                         (i_mem_addr == ADDR_SP)     ? stk.sp :
                         (i_mem_addr == ADDR_SBS)    ? {4'h0, stk.stack_bank_selector} : 8'h00;

  // ==========================================================
  // nibble written in each push step
  always_comb begin
    push_nib = 4'h0;
    if (pair_push) begin
      push_nib = (cnt_q == 3'h0) ? data_q[7:4] : data_q[3:0];
    end else if ((cmd_q == CMD_INT) && (cnt_q == 3'h0)) begin
      push_nib = {carry, skip_q};
    end else if ((cmd_q == CMD_INT) && (cnt_q == 3'h1)) begin
      push_nib = {ist_q, mbe_q, rbe_q};
    end else begin
      case (call_idx)
        3'h0:    push_nib = pc_q[7:4];
        3'h1:    push_nib = pc_q[3:0];
        3'h2:    push_nib = {mbe_q, rbe_q, 1'b0, pc_q[12]};
        default: push_nib = pc_q[11:8];
      endcase
    end
  end

  // ==========================================================
  // stack unit hookup
  assign stk.push      = (state_q == ST_PUSH);
  assign stk.pop       = (state_q == ST_POP);
  assign stk.sp_we     = wr_sp;
  assign stk.sp_wdata  = i_mem_wdata;
  assign stk.sbs_we    = wr_sbs;
  assign stk.sbs_wdata = i_mem_wdata[3:0];

  swb_stack_unit u_stack (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .stk     (stk.unit)
  );

  swb_carry_unit u_carry (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_op        (i_cy_op),
    .i_alu_carry (i_alu_carry),
    .i_mem_bit   (i_mem_bit),
    .i_load      (interrupt_exit_op_cy),
    .i_load_val  (i_stk_rdata[3]),
    .o_carry     (carry),
    .o_skip      (o_skip_carry)
  );

  // ==========================================================
  // frame sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:   if (start) state_d = push_cmd ? ST_PUSH : ST_POP;
      ST_PUSH:   if (last) state_d = ST_FINISH;
      ST_POP:    if (last) state_d = ST_FINISH;
      ST_FINISH: state_d = ST_IDLE;
      default:   state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q    <= ST_IDLE;
      cmd_q      <= CMD_NONE;
      cnt_q      <= 3'h0;
      len_q      <= NIB_PAIR;
      vec_q      <= 8'h00;
      rd_valid_q <= 1'b0;
      rd_idx_q   <= 3'h0;
      done_q     <= 1'b0;
    end else begin
      state_q    <= state_d;
      cnt_q      <= start ? 3'h0 : cnt_q + 3'h1;
      rd_valid_q <= stk.pop;
      rd_idx_q   <= cnt_q;
      done_q     <= (state_q == ST_FINISH);
      if (start) begin
        cmd_q <= i_cmd;
        len_q <= start_len;
        vec_q <= i_vec_word;
      end
    end
  end

  // return address and pair data, latched on push, gathered on pop
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pc_q   <= 13'h0000;
      data_q <= 8'h00;
    end else begin
      if (start) begin
        pc_q   <= i_ret_pc;
        data_q <= (i_cmd == CMD_PUSH_BS) ? bs_word : i_push_data;
      end else if (cap_ret) begin
        case (rd_idx_q)
          3'h0:    pc_q[11:8] <= i_stk_rdata;
          3'h1:    pc_q[12]   <= i_stk_rdata[0];
          3'h2:    pc_q[3:0]  <= i_stk_rdata;
          3'h3:    pc_q[7:4]  <= i_stk_rdata;
          default: pc_q       <= pc_q;
        endcase
      end else if (cap_data) begin
        if (rd_idx_q == 3'h0) begin
          data_q[3:0] <= i_stk_rdata;
        end else begin
          data_q[7:4] <= i_stk_rdata;
        end
      end
    end
  end

  // ==========================================================
  // status word
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ist_q  <= IST_S0;
      mbe_q  <= 1'b0;
      rbe_q  <= 1'b0;
      boot_q <= 1'b1;
    end else begin
      boot_q <= 1'b0;
      if (boot_q) begin
        mbe_q <= i_boot_word[BOOT_MBE_BIT];
        rbe_q <= i_boot_word[BOOT_RBE_BIT];
      end else if (int_done) begin
        ist_q <= ist_next;
        mbe_q <= vec_q[VEC_MBE_BIT];
        rbe_q <= vec_q[VEC_RBE_BIT];
      end else if (ret_bank) begin
        {mbe_q, rbe_q} <= i_stk_rdata[3:2];
      end else if (interrupt_exit_op_psw) begin
        {ist_q, mbe_q, rbe_q} <= i_stk_rdata;
      end else if (wr_psw_lo) begin
        {ist_q, mbe_q, rbe_q} <= i_mem_wdata[3:0];
      end
    end
  end

  // skip bits have no memory write path
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      skip_q <= 3'h0;
    end else if (interrupt_exit_op_cy) begin
      skip_q <= i_stk_rdata[2:0];
    end else if (i_skip_we) begin
      skip_q <= i_skip_state;
    end
  end

  // ==========================================================
  // bank selection
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mbs_q <= MB_RESET;
      rbs_q <= RB_RESET;
    end else begin
      if (cap_bs && (rd_idx_q == 3'h1)) begin
        mbs_q <= i_stk_rdata;
      end else if (i_sel_mb_we && mb_legal) begin
        mbs_q <= i_sel_mb;
      end
      if (cap_bs && (rd_idx_q == 3'h0)) begin
        rbs_q <= i_stk_rdata[1:0];
      end else if (i_sel_rb_we) begin
        rbs_q <= i_sel_rb;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mem_rdata_q <= 8'h00;
    end else if (i_mem_re) begin
      mem_rdata_q <= rd_mux;
    end
  end

  // ==========================================================
  // outputs
  assign o_busy           = !idle;
  assign o_done           = done_q;
  assign o_pop_pc         = pc_q;
  assign o_pop_data       = data_q;
  assign o_stk_addr       = stk.addr;
  assign o_stk_we         = stk.push;
  assign o_stk_re         = stk.pop;
  assign o_stk_wdata      = push_nib;
  assign o_carry          = carry;
  assign o_data_bank_hi   = mbe_q ? mbs_q : i_fixed_bank;
  assign o_reg_bank       = rbe_q ? rbs_q : RB_FIXED;
  assign o_irq_allow_all  = (ist_q == IST_S0);
  assign o_irq_allow_high = (ist_q == IST_S0) || (ist_q == IST_S1);
  assign o_mem_rdata      = mem_rdata_q;
  assign o_extended_mode  = extended;

  // ==========================================================
  // checks
  sequence s_call_go;
    idle && (i_cmd == CMD_CALL);
  endsequence

  sequence s_int_go;
    idle && (i_cmd == CMD_INT);
  endsequence

  call_frame_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_call_go |=> o_stk_we [*4] ##1 !o_stk_we)
    else $error("call frame length wrong");
  call_bank_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_call_go |-> ##3 (o_stk_wdata[3] == mbe_q && o_stk_wdata[2] == rbe_q && !o_stk_wdata[1]))
    else $error("call frame enable nibble wrong");
  int_frame_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_int_go |=> o_stk_we [*6] ##1 (!o_stk_we && o_busy) ##1 o_done)
    else $error("interrupt frame length wrong");
  int_status_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (s_int_go ##0 (ist_q == IST_S0)) |-> ##8 (ist_q == IST_S1))
    else $error("interrupt status did not step up");
  int_vector_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_int_go |-> ##8 (mbe_q == vec_q[VEC_MBE_BIT] && rbe_q == vec_q[VEC_RBE_BIT]))
    else $error("vector enables not loaded");
  boot_load_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    boot_q |=> (mbe_q == $past(i_boot_word[BOOT_MBE_BIT]) && rbe_q == $past(i_boot_word[BOOT_RBE_BIT])))
    else $error("boot enables not loaded");
  reg_bank_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !rbe_q |-> o_reg_bank == RB_FIXED)
    else $error("register bank not forced");
  data_bank_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    mbe_q |-> o_data_bank_hi == mbs_q)
    else $error("data bank not from selector");
  irq_lock_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (ist_q == IST_S2) |-> !o_irq_allow_all && !o_irq_allow_high)
    else $error("interrupts allowed in locked status");
  sel_mb_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_sel_mb_we && !mb_legal && !cap_bs) |=> $stable(mbs_q))
    else $error("illegal data bank accepted");

endmodule : swb_ctx

//--- swb_stk_mem.sv
// ==========================================================
// nibble-wide stack memory of the sequencer side
module swb_stk_mem (
  // stack port
  input  wire logic        i_clk,
  input  wire logic [11:0] i_addr,
  input  wire logic        i_we,
  input  wire logic        i_re,
  input  wire logic [3:0]  i_wdata,
  output logic      [3:0]  o_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] mem [512];
  logic [3:0] rdata_q = 4'h0;
  // read data one cycle after the strobe, scrambled when idle
  always @(posedge i_clk) begin
    if (i_we) begin
      mem[i_addr[8:0]] <= i_wdata;
    end
    rdata_q <= i_re ? mem[i_addr[8:0]] : ~rdata_q;
  end
  assign o_rdata = rdata_q;
endmodule : swb_stk_mem

//--- swb_ctx_tb.sv
// ==========================================================
// context block bench
module swb_ctx_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import swb_pkg::*;
  logic          i_clk = 0, i_rst_n = 0, i_alu_carry = 0, i_mem_bit = 0, i_skip_we = 0;
  logic          i_sel_mb_we = 0, i_sel_rb_we = 0, i_mem_we = 0, i_mem_re = 0, cy;
  logic          o_busy, o_done, o_stk_we, o_stk_re, o_carry, o_skip_carry;
  logic          o_irq_allow_all, o_irq_allow_high, o_extended_mode;
  swb_cmd_type   i_cmd = CMD_NONE;
  swb_cy_op_type i_cy_op = CY_NONE;
  logic [12:0]   i_ret_pc = '0, o_pop_pc, pc;
  logic [7:0]    i_push_data = '0, i_vec_word = '0, i_boot_word = 8'h40, i_mem_wdata = '0;
  logic [7:0]    o_pop_data, o_mem_rdata, d;
  logic [11:0]   i_mem_addr = '0, o_stk_addr;
  logic [3:0]    i_stk_rdata, o_stk_wdata, i_sel_mb = '0, i_fixed_bank = '0, o_data_bank_hi;
  logic [2:0]    i_skip_state = '0;
  logic [1:0]    i_sel_rb = '0, o_reg_bank;
  int            err_count = 0, n_tests = 0;

  swb_ctx dut (.*);
  swb_stk_mem stk (.i_clk(i_clk), .i_addr(o_stk_addr), .i_we(o_stk_we), .i_re(o_stk_re),
                   .i_wdata(o_stk_wdata), .o_rdata(i_stk_rdata));
  initial forever #25 i_clk = ~i_clk;

  task cyc; @(posedge i_clk); #1; endtask : cyc
  task chk(input string nm, input logic [12:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task mw(input logic [11:0] a, input logic [7:0] v);
    i_mem_addr = a; i_mem_wdata = v; i_mem_we = 1; cyc; i_mem_we = 0; cyc;
  endtask : mw
  task mr(input logic [11:0] a);
    i_mem_addr = a; i_mem_re = 1; cyc; i_mem_re = 0; cyc;
  endtask : mr
  task frame(input swb_cmd_type c);
    i_cmd = c; cyc; i_cmd = CMD_NONE;
    chk("busy", o_busy, 1);
    for (int k = 0; k < 20 && o_done !== 1'b1; k++) cyc;
    chk("done", o_done, 1);
    cyc;
  endtask : frame
  function logic cy_exp(swb_cy_op_type op, logic c, a, m);
    case (op)
      CY_SET: return 1'b1;
      CY_CLR: return 1'b0;
      CY_NOT: return ~c;
      CY_ARITH: return a;
      CY_MOVE_IN: return m;
      CY_AND: return c & m;
      CY_OR: return c | m;
      CY_XOR: return c ^ m;
      default: return c;
    endcase
  endfunction : cy_exp
  task close_out;
    $display("Checks %0d, errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  initial begin
    #200us; err_count++; close_out;
  end
  initial begin
    d = 8'($urandom(88));
    repeat (12) @(posedge i_clk);
    #1 i_rst_n = 1; cyc; cyc;
    chk("mode", o_extended_mode, 1);
    mr(ADDR_SBS); chk("sbs", o_mem_rdata[3:0], SBS_RESET);
    mr(ADDR_PSW_LO); chk("boot", o_mem_rdata[3:0], 4'h1);
    i_fixed_bank = 4'($urandom); i_sel_mb_we = 1; i_sel_mb = MB_BANK1; cyc;
    chk("fixbank", o_data_bank_hi, i_fixed_bank);
    i_sel_mb = 4'h5; i_sel_rb_we = 1; i_sel_rb = 2'h3; cyc; i_sel_mb_we = 0; i_sel_rb_we = 0;
    mw(ADDR_PSW_LO, 8'h02); chk("dbank", o_data_bank_hi, MB_BANK1);
    chk("rb0", o_reg_bank, RB_FIXED);
    mw(ADDR_PSW_LO, 8'h01); chk("rb", o_reg_bank, 2'h3);
    for (int s = 0; s < 4; s++) begin
      mw(ADDR_PSW_LO, {4'h0, s[1:0], 2'b11});
      chk("all", o_irq_allow_all, s == 0);
      chk("high", o_irq_allow_high, s < 2);
    end
    mw(ADDR_SBS, 8'h01); mw(ADDR_SP, 8'h00); mw(ADDR_PSW_LO, 8'h03);
    d = 8'($urandom); i_push_data = d; frame(CMD_PUSH_PAIR);
    chk("hi", stk.mem[9'h1FF], d[7:4]);
    chk("lo", stk.mem[9'h1FE], d[3:0]);
    i_push_data = ~d; frame(CMD_POP_PAIR); chk("pair", o_pop_data, d);
    pc = 13'($urandom); i_ret_pc = pc; frame(CMD_CALL);
    chk("c0", stk.mem[9'h1FF], pc[7:4]);
    chk("c1", stk.mem[9'h1FE], pc[3:0]);
    chk("c2", stk.mem[9'h1FD], {3'b110, pc[12]});
    chk("c3", stk.mem[9'h1FC], pc[11:8]);
    mw(ADDR_PSW_LO, 8'h04); i_ret_pc = ~pc;
    frame(CMD_RET); chk("pc", o_pop_pc, pc);
    mr(ADDR_PSW_LO); chk("ret", o_mem_rdata[3:0], 4'h7);
    i_skip_state = 3'($urandom); i_skip_we = 1; i_cy_op = CY_SET; cyc;
    i_skip_we = 0; i_cy_op = CY_NONE; i_vec_word = 8'h80; frame(CMD_INT);
    chk("i0", stk.mem[9'h1FF], {1'b1, i_skip_state});
    chk("i1", stk.mem[9'h1FE], 4'h7);
    mr(ADDR_PSW_LO); chk("int", o_mem_rdata[3:0], 4'hA);
    i_cy_op = CY_CLR; cyc; i_cy_op = CY_NONE; frame(CMD_INTERRUPT_EXIT_OP);
    mr(ADDR_PSW_LO); chk("interrupt_exit_op", o_mem_rdata[3:0], 4'h7);
    chk("recy", o_carry, 1);
    mw(ADDR_PSW_HI, 8'h00); mr(ADDR_PSW_HI);
    chk("fb1", o_mem_rdata[3:0], {1'b1, i_skip_state});
    i_sel_mb_we = 1; i_sel_mb = MB_BANK15; i_sel_rb_we = 1; i_sel_rb = 2'h2; cyc;
    i_sel_mb_we = 0; i_sel_rb_we = 0; frame(CMD_PUSH_BS);
    i_sel_rb_we = 1; i_sel_rb = 2'h1; cyc; i_sel_rb_we = 0; frame(CMD_POP_BS);
    chk("bs", o_pop_data, {MB_BANK15, 4'h2});
    chk("rbs", o_reg_bank, 2'h2);
    for (int i = 0; i < 40; i++) begin
      i_cy_op = (i == 0) ? CY_SET : swb_cy_op_type'($urandom_range(9, 1));
      i_alu_carry = 1'($urandom); i_mem_bit = 1'($urandom); #1;
      chk("skip", o_skip_carry, i_cy_op == CY_SKT && cy);
      cy = cy_exp(i_cy_op, cy, i_alu_carry, i_mem_bit); cyc;
      chk("carry", o_carry, cy);
    end
    close_out;
  end
endmodule : swb_ctx_tb
